// ### design/crfda_core.sv
// working register file, data space decoder, internal sram and program counter
`timescale 1ns/1ps

module crfda_core
    import crfda_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic alu_imm,
    input wire logic [4:0] rd_idx,
    input wire logic [4:0] src_reg,
    input wire logic alu_we,
    input wire logic [7:0] alu_result,
    output logic [7:0] rd_data,
    output logic [7:0] src_data,
    input wire logic mem_req,
    input wire logic [2:0] mem_mode,
    input wire logic [1:0] mem_ptr,
    input wire logic mem_we,
    input wire logic [15:0] mem_daddr,
    input wire logic [5:0] mem_disp,
    input wire logic [5:0] mem_io_addr,
    input wire logic [7:0] mem_wdata,
    output logic mem_busy,
    output logic mem_done,
    output logic [7:0] mem_rdata,
    output logic io_sel,
    output logic io_we,
    output logic [5:0] io_addr,
    output logic [7:0] io_wdata,
    input wire logic [7:0] io_rdata,
    input wire logic [2:0] pc_op,
    input wire logic [11:0] rel_k,
    output logic [10:0] pc,
    input wire logic const_req,
    output logic [10:0] const_word_addr,
    input wire logic [15:0] const_word,
    output logic [7:0] const_data,
    output logic const_valid
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        crfda_state_t state;
        logic [NUM_REGS-1:0][7:0] regs;
        logic [SRAM_BYTES-1:0][7:0] sram;
        logic [10:0] pc;
        logic [15:0] addr;
        logic we;
        logic [7:0] wdata;
        logic post_inc;
        logic [1:0] ptr_sel;
        logic [7:0] rdata;
        logic done;
        logic [7:0] cdata;
        logic cvalid;
    } crfda_st_t;

    crfda_st_t s_q;
    crfda_st_t s_d;

    // ----------------------------------------------------------------
    // decode helpers
    // ----------------------------------------------------------------
    function automatic logic [1:0] region(input logic [15:0] a);
        if (a < IO_BASE) begin
            region = RGN_REG;
        end else if (a < SRAM_BASE) begin
            region = RGN_IO;
        end else if (a < SRAM_END) begin
            region = RGN_SRAM;
        end else begin
            region = RGN_NONE;
        end
    endfunction

    function automatic logic [4:0] ptr_lo(input logic [1:0] sel);
        case (sel)
            PTR_X: ptr_lo = X_LO;
            PTR_Y: ptr_lo = Y_LO;
            default: ptr_lo = Z_LO;
        endcase
    endfunction

    function automatic logic [15:0] ptr_val(input logic [NUM_REGS-1:0][7:0] r, input logic [1:0] sel);
        logic [4:0] lo;
        lo = ptr_lo(sel);
        ptr_val = {r[lo + 5'h01], r[lo]};
    endfunction

    logic [4:0] dst_idx;
    logic [15:0] base;
    logic [15:0] zptr;
    logic [1:0] cur_rgn;

    // immediate forms carry a four-bit field, so the upper bank is forced
    assign dst_idx = alu_imm ? (IMM_BANK | {1'b0, rd_idx[3:0]}) : rd_idx;
    assign base = ptr_val(s_q.regs, mem_ptr);
    assign zptr = ptr_val(s_q.regs, PTR_Z);
    assign cur_rgn = region(s_q.addr);

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        logic [15:0] a;
        logic [15:0] np;
        logic [4:0] lo;
        logic [6:0] sidx;
        a = 16'h0000;
        np = 16'h0000;
        lo = 5'h00;
        sidx = 7'h00;
        s_d = s_q;
        s_d.done = 1'b0;
        s_d.cvalid = 1'b0;

        // both operands are read combinationally; only the result is written, to dst_idx, at this edge
        if (alu_we) begin
            s_d.regs[dst_idx] = alu_result;
        end

        case (pc_op)
            PC_NEXT: s_d.pc = s_q.pc + 11'h001;
            PC_SKIP: s_d.pc = s_q.pc + 11'h002;
            PC_PTR: s_d.pc = zptr[10:0];
            PC_REL: s_d.pc = s_q.pc + rel_k[10:0] + 11'h001;
            default: s_d.pc = s_q.pc;
        endcase

        if (const_req) begin
            s_d.cdata = zptr[0] ? const_word[15:8] : const_word[7:0];
            s_d.cvalid = 1'b1;
        end

        case (s_q.state)
            ST_IDLE: begin
                if (mem_req) begin
                    case (mem_mode)
                        MODE_DIRECT: a = mem_daddr;
                        MODE_DISP: a = base + {10'h000, mem_disp};
                        MODE_PREDEC: a = base - 16'h0001;
                        MODE_IO: a = IO_BASE + {10'h000, mem_io_addr};
                        default: a = base;
                    endcase
                    if (mem_mode == MODE_PREDEC) begin
                        lo = ptr_lo(mem_ptr);
                        s_d.regs[lo] = a[7:0];
                        s_d.regs[lo + 5'h01] = a[15:8];
                    end
                    s_d.addr = a;
                    s_d.we = mem_we;
                    s_d.wdata = mem_wdata;
                    s_d.ptr_sel = mem_ptr;
                    s_d.post_inc = (mem_mode == MODE_POSTINC);
                    // sram needs an extra cycle; everything else answers next
                    s_d.state = (region(a) == RGN_SRAM) ? ST_SRAM : ST_ACC;
                end
            end
            ST_SRAM: begin
                s_d.state = ST_ACC;
            end
            ST_ACC: begin
                sidx = 7'(s_q.addr - SRAM_BASE);
                case (cur_rgn)
                    RGN_REG: begin
                        s_d.rdata = s_q.regs[s_q.addr[4:0]];
                        if (s_q.we) begin
                            s_d.regs[s_q.addr[4:0]] = s_q.wdata;
                        end
                    end
                    RGN_IO: s_d.rdata = io_rdata;
                    RGN_SRAM: begin
                        s_d.rdata = s_q.sram[sidx];
                        if (s_q.we) begin
                            s_d.sram[sidx] = s_q.wdata;
                        end
                    end
                    default: s_d.rdata = 8'h00;
                endcase
                if (s_q.post_inc) begin
                    np = s_q.addr + 16'h0001;
                    lo = ptr_lo(s_q.ptr_sel);
                    s_d.regs[lo] = np[7:0];
                    s_d.regs[lo + 5'h01] = np[15:8];
                end
                s_d.done = 1'b1;
                s_d.state = ST_IDLE;
            end
            default: s_d.state = ST_IDLE;
        endcase
    end

    // a single undivided clock drives every flip-flop
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
            s_q.state <= ST_IDLE;
            s_q.pc <= PC_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign rd_data = s_q.regs[dst_idx];
    assign src_data = s_q.regs[src_reg];
    assign mem_busy = (s_q.state != ST_IDLE);
    assign mem_done = s_q.done;
    assign mem_rdata = s_q.rdata;
    assign io_sel = (s_q.state == ST_ACC) && (cur_rgn == RGN_IO);
    assign io_we = io_sel && s_q.we;
    assign io_addr = 6'(s_q.addr - IO_BASE);
    assign io_wdata = s_q.wdata;
    assign pc = s_q.pc;
    // words beyond the 2k space alias, only the low 11 word bits are used
    assign const_word_addr = zptr[11:1];
    assign const_data = s_q.cdata;
    assign const_valid = s_q.cvalid;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    logic take;
    assign take = mem_req && (s_q.state == ST_IDLE);

    sram_latency_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        take && region(s_d.addr) == RGN_SRAM |=> !mem_done ##1 !mem_done ##1 mem_done)
        else $error("sram access did not take two cycles");

    reg_latency_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        take && region(s_d.addr) != RGN_SRAM |=> !mem_done ##1 mem_done)
        else $error("non-sram access did not answer in one cycle");

    imm_bank_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        alu_we && alu_imm && !take && s_q.state != ST_ACC
        |=> s_q.regs[{1'b1, $past(rd_idx[3:0])}] == $past(alu_result))
        else $error("immediate write missed the upper bank");

    alu_wb_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        alu_we && !alu_imm && $past(rst_n) && s_q.state == ST_IDLE && !mem_req
        |=> s_q.regs[$past(rd_idx)] == $past(alu_result))
        else $error("alu result not written back in one cycle");

    predec_ptr_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        take && mem_mode == MODE_PREDEC |=> ptr_val(s_q.regs, s_q.ptr_sel) == $past(base) - 16'h0001
        && s_q.addr == $past(base) - 16'h0001)
        else $error("pre-decrement pointer or address wrong");

    postinc_ptr_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        s_q.state == ST_ACC && s_q.post_inc |=> ptr_val(s_q.regs, $past(s_q.ptr_sel)) == $past(s_q.addr) + 16'h0001)
        else $error("post-increment pointer not advanced after access");

    disp_addr_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        take && mem_mode == MODE_DISP |=> s_q.addr == $past(base) + {10'h000, $past(mem_disp)})
        else $error("displacement address wrong");

    pc_ptr_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        pc_op == PC_PTR |=> pc == $past(zptr[10:0]))
        else $error("pointer jump did not load z");

    pc_rel_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        pc_op == PC_REL |=> pc == 11'($past(pc) + $past(rel_k[10:0]) + 11'h001))
        else $error("offset jump target wrong");

    io_window_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        take && mem_mode == MODE_IO |=> io_sel && io_addr == $past(mem_io_addr))
        else $error("io direct access not mapped at plus 32");

    io_write_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        take && mem_mode == MODE_IO && mem_we |=> io_we && io_wdata == $past(mem_wdata))
        else $error("io direct write not presented to the io port");

    // address forming: the latched address must follow the mode seen at the take edge
    direct_addr_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        take && mem_mode == MODE_DIRECT |=> s_q.addr == $past(mem_daddr))
        else $error("direct address not taken from the second word");

    ind_addr_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        take && mem_mode == MODE_IND |=> s_q.addr == $past(base))
        else $error("plain indirect address differs from the pointer");

    postinc_addr_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        take && mem_mode == MODE_POSTINC |=> s_q.addr == $past(base))
        else $error("post-increment did not use the old pointer");

    sram_busy_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        take && region(s_d.addr) == RGN_SRAM |=> mem_busy ##1 mem_busy ##1 !mem_busy)
        else $error("sram access busy span not two cycles");

    reg_read_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        s_q.state == ST_ACC && cur_rgn == RGN_REG && !s_q.we |=> mem_rdata == $past(s_q.regs[s_q.addr[4:0]]))
        else $error("register read through data space wrong");

    unmapped_read_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        s_q.state == ST_ACC && cur_rgn == RGN_NONE |=> mem_rdata == 8'h00)
        else $error("unmapped address did not read zero");

    const_byte_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        const_req |=> const_valid
        && const_data == ($past(zptr[0]) ? $past(const_word[15:8]) : $past(const_word[7:0])))
        else $error("constant load picked the wrong byte");

    pc_step_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        pc_op == PC_NEXT |=> pc == 11'($past(pc) + 11'h001))
        else $error("program counter did not step by one");

    pc_skip_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        pc_op == PC_SKIP |=> pc == 11'($past(pc) + 11'h002))
        else $error("program counter did not skip a word");

    // covers for the main access kinds, offset jumps and constant loads; sram answers one cycle after the others
    sram_write_c: cover property (@(posedge core_clk) disable iff (!rst_n)
        take && mem_we && region(s_d.addr) == RGN_SRAM ##3 mem_done);
    postinc_c: cover property (@(posedge core_clk) disable iff (!rst_n)
        take && mem_mode == MODE_POSTINC ##[2:3] mem_done);
    io_write_c: cover property (@(posedge core_clk) disable iff (!rst_n) io_sel && io_we);
    rel_jump_c: cover property (@(posedge core_clk) disable iff (!rst_n) pc_op == PC_REL && rel_k[11]);
    const_hi_c: cover property (@(posedge core_clk) disable iff (!rst_n) const_req && zptr[0]);

endmodule

// ### pkg/crfda_pkg.sv
// constants and types shared by the register file and data addressing block
package crfda_pkg;
    localparam int NUM_REGS = 32;
    localparam int SRAM_BYTES = 128;
    localparam int PC_W = 11;
    localparam logic [15:0] REG_BASE = 16'h0000;
    localparam logic [15:0] IO_BASE = 16'h0020;
    localparam logic [15:0] SRAM_BASE = 16'h0060;
    localparam logic [15:0] SRAM_END = 16'h00e0;
    localparam logic [4:0] IMM_BANK = 5'h10;
    localparam logic [4:0] X_LO = 5'h1a;
    localparam logic [4:0] Y_LO = 5'h1c;
    localparam logic [4:0] Z_LO = 5'h1e;
    localparam logic [1:0] PTR_X = 2'h0;
    localparam logic [1:0] PTR_Y = 2'h1;
    localparam logic [1:0] PTR_Z = 2'h2;
    localparam logic [2:0] MODE_DIRECT = 3'h0;
    localparam logic [2:0] MODE_DISP = 3'h1;
    localparam logic [2:0] MODE_IND = 3'h2;
    localparam logic [2:0] MODE_PREDEC = 3'h3;
    localparam logic [2:0] MODE_POSTINC = 3'h4;
    localparam logic [2:0] MODE_IO = 3'h5;
    localparam logic [1:0] RGN_REG = 2'h0;
    localparam logic [1:0] RGN_IO = 2'h1;
    localparam logic [1:0] RGN_SRAM = 2'h2;
    localparam logic [1:0] RGN_NONE = 2'h3;
    localparam logic [2:0] PC_HOLD = 3'h0;
    localparam logic [2:0] PC_NEXT = 3'h1;
    localparam logic [2:0] PC_SKIP = 3'h2;
    localparam logic [2:0] PC_PTR = 3'h3;
    localparam logic [2:0] PC_REL = 3'h4;
    localparam logic [10:0] PC_RESET = 11'h000;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_SRAM = 3'b010,
        ST_ACC = 3'b100
    } crfda_state_t;
endpackage

// ### tb/crfda_io_model.sv
// behavioural io register space answering the core's io port
`timescale 1ns/1ps
module crfda_io_model (
    input wire logic core_clk,
    input wire logic io_sel,
    input wire logic io_we,
    input wire logic [5:0] io_addr,
    input wire logic [7:0] io_wdata,
    output logic [7:0] io_rdata
);
    logic [7:0] mem [64];
    // seeded contents so a read before any write still tells addresses apart
    initial begin
        for (int i = 0; i < 64; i++) mem[i] = 8'(i) ^ 8'h5a;
    end
    // outside an access cycle the bus shows the inverted stored byte, never the true value
    assign io_rdata = io_sel ? mem[io_addr] : ~mem[io_addr];
    always @(posedge core_clk) begin
        if (io_sel && io_we) mem[io_addr] <= io_wdata;
    end
endmodule

// ### tb/testbench.sv
// self-checking bench for the register file and data addressing core
`timescale 1ns/1ps
module testbench;
    import crfda_pkg::*;
    logic core_clk, rst_n, alu_imm, alu_we, mem_req, mem_we, const_req;
    logic [4:0] rd_idx, src_reg;
    logic [7:0] alu_result, rd_data, src_data, mem_wdata, mem_rdata, io_wdata, io_rdata, const_data;
    logic [2:0] mem_mode, pc_op;
    logic [1:0] mem_ptr;
    logic [15:0] mem_daddr, const_word;
    logic [5:0] mem_disp, mem_io_addr, io_addr;
    logic mem_busy, mem_done, io_sel, io_we, const_valid;
    logic [11:0] rel_k;
    logic [10:0] pc, const_word_addr, pm;
    logic [7:0] mr [32];
    logic [7:0] ms [128];
    logic [7:0] mio [64];
    int bad_count, checks_done;
    crfda_core DUT (.core_clk(core_clk), .rst_n(rst_n), .alu_imm(alu_imm), .rd_idx(rd_idx), .src_reg(src_reg),
        .alu_we(alu_we), .alu_result(alu_result), .rd_data(rd_data), .src_data(src_data), .mem_req(mem_req),
        .mem_mode(mem_mode), .mem_ptr(mem_ptr), .mem_we(mem_we), .mem_daddr(mem_daddr), .mem_disp(mem_disp),
        .mem_io_addr(mem_io_addr), .mem_wdata(mem_wdata), .mem_busy(mem_busy), .mem_done(mem_done),
        .mem_rdata(mem_rdata), .io_sel(io_sel), .io_we(io_we), .io_addr(io_addr), .io_wdata(io_wdata),
        .io_rdata(io_rdata), .pc_op(pc_op), .rel_k(rel_k), .pc(pc), .const_req(const_req),
        .const_word_addr(const_word_addr), .const_word(const_word), .const_data(const_data),
        .const_valid(const_valid));
    crfda_io_model io_far (.core_clk(core_clk), .io_sel(io_sel), .io_we(io_we), .io_addr(io_addr),
        .io_wdata(io_wdata), .io_rdata(io_rdata));
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    function automatic logic [15:0] ptrv(input logic [1:0] p);
        return {mr[27 + 2 * p], mr[26 + 2 * p]};
    endfunction
    task automatic setp(input logic [1:0] p, input logic [15:0] v);
        mr[26 + 2 * p] = v[7:0];
        mr[27 + 2 * p] = v[15:8];
    endtask
    // immediate-class writes land in the upper bank only
    task automatic wr(input logic [4:0] idx, input logic [7:0] v, input logic imm);
        @(negedge core_clk);
        alu_we = 1'b1; alu_imm = imm; rd_idx = idx; alu_result = v;
        mr[imm ? {1'b1, idx[3:0]} : idx] = v;
        @(negedge core_clk);
        alu_we = 1'b0; alu_imm = 1'b0;
    endtask
    task automatic wrp(input logic [1:0] p, input logic [15:0] v);
        wr(5'(26 + 2 * p), v[7:0], 1'b0);
        wr(5'(27 + 2 * p), v[15:8], 1'b0);
    endtask
    task automatic chk_regs();
        for (int i = 0; i < 32; i++) begin
            @(negedge core_clk);
            rd_idx = 5'(i); src_reg = 5'(31 - i);
            #1;
            check(rd_data, mr[i]);
            check(src_data, mr[31 - i]);
        end
    endtask
    task automatic mem(input logic [2:0] md, input logic [1:0] p, input logic w, input logic [15:0] a,
                       input logic [5:0] d, input logic [7:0] wd);
        int n;
        logic [15:0] pv, ea;
        logic [7:0] ex;
        pv = ptrv(p);
        case (md)
            MODE_DIRECT: ea = a;
            MODE_DISP: ea = pv + d;
            MODE_IND: ea = pv;
            MODE_PREDEC: ea = pv - 16'h0001;
            MODE_POSTINC: ea = pv;
            default: ea = 16'h0020 + a[5:0];
        endcase
        if (md == MODE_PREDEC) setp(p, ea);
        if (md == MODE_POSTINC) setp(p, pv + 16'h0001);
        ex = ea < 32 ? mr[ea] : ea < 96 ? mio[ea - 32] : ea < 224 ? ms[ea - 96] : 8'h00;
        if (w && ea < 32) mr[ea] = wd;
        else if (w && ea < 96) mio[ea - 32] = wd;
        else if (w && ea < 224) ms[ea - 96] = wd;
        @(negedge core_clk);
        mem_req = 1'b1; mem_mode = md; mem_ptr = p; mem_we = w; mem_daddr = a;
        mem_disp = d; mem_io_addr = a[5:0]; mem_wdata = wd;
        @(negedge core_clk);
        mem_req = 1'b0;
        check(mem_busy, 1'b1);
        n = 0;
        while (mem_done !== 1'b1 && n < 6) begin
            @(negedge core_clk);
            n++;
        end
        check(mem_busy, 1'b0);
        check(16'(n), (ea >= 96 && ea < 224) ? 16'h0002 : 16'h0001);
        if (!w) check(mem_rdata, ex);
    endtask
    task automatic pcop(input logic [2:0] op, input logic [11:0] k);
        @(negedge core_clk);
        pc_op = op; rel_k = k;
        case (op)
            PC_NEXT: pm = pm + 11'h001;
            PC_SKIP: pm = pm + 11'h002;
            PC_PTR: pm = ptrv(2'h2);
            PC_REL: pm = pm + k[10:0] + 11'h001;
            default: pm = pm;
        endcase
        @(negedge core_clk);
        pc_op = PC_HOLD;
        check(pc, pm);
    endtask
    task automatic cload(input logic [15:0] z, input logic [15:0] wv);
        wrp(2'h2, z);
        @(negedge core_clk);
        const_req = 1'b1; const_word = wv;
        #1;
        check(const_word_addr, z[11:1]);
        @(negedge core_clk);
        const_req = 1'b0;
        check(const_valid, 1'b1);
        check(const_data, z[0] ? wv[15:8] : wv[7:0]);
    endtask
    initial begin
        #100000;
        bad_count++;
        conclude();
    end
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        logic [2:0] md;
        logic [1:0] p;
        logic [15:0] a;
        {rst_n, alu_imm, alu_we, mem_req, mem_we, const_req, rd_idx, src_reg, alu_result} = '0;
        {mem_mode, mem_ptr, mem_daddr, mem_disp, mem_io_addr, mem_wdata, pc_op, rel_k, const_word} = '0;
        bad_count = 0; checks_done = 0; pm = PC_RESET;
        for (int i = 0; i < 32; i++) mr[i] = 8'h00;
        for (int i = 0; i < 128; i++) ms[i] = 8'h00;
        for (int i = 0; i < 64; i++) mio[i] = 8'(i) ^ 8'h5a;
        void'($urandom(74));
        repeat (4) @(posedge core_clk);
        @(negedge core_clk);
        rst_n = 1'b1;
        check(pc, PC_RESET);
        for (int i = 0; i < 32; i++) wr(5'(i), 8'($urandom), 1'b0);
        wr(5'h03, 8'($urandom), 1'b1);
        wr(5'h1e, 8'($urandom), 1'b1);
        chk_regs();
        wrp(PTR_X, 16'h0061);
        wrp(PTR_Y, 16'h00a0);
        wrp(PTR_Z, 16'h00df);
        mem(MODE_DIRECT, PTR_X, 1'b1, SRAM_BASE, 6'h00, 8'h3c);
        mem(MODE_DIRECT, PTR_X, 1'b0, SRAM_BASE, 6'h00, 8'h00);
        mem(MODE_DIRECT, PTR_X, 1'b0, 16'h0005, 6'h00, 8'h00);
        mem(MODE_DIRECT, PTR_X, 1'b1, 16'h0007, 6'h00, 8'h99);
        mem(MODE_DIRECT, PTR_X, 1'b0, 16'h0025, 6'h00, 8'h00);
        mem(MODE_IO, PTR_X, 1'b1, 16'h0005, 6'h00, 8'h77);
        mem(MODE_IO, PTR_X, 1'b0, 16'h003f, 6'h00, 8'h00);
        mem(MODE_DIRECT, PTR_X, 1'b0, 16'h0025, 6'h00, 8'h00);
        mem(MODE_DIRECT, PTR_X, 1'b1, SRAM_END, 6'h00, 8'h5e);
        mem(MODE_DIRECT, PTR_X, 1'b0, SRAM_END, 6'h00, 8'h00);
        mem(MODE_POSTINC, PTR_X, 1'b1, 16'h0000, 6'h00, 8'hc4);
        mem(MODE_PREDEC, PTR_X, 1'b0, 16'h0000, 6'h00, 8'h00);
        mem(MODE_DISP, PTR_Y, 1'b1, 16'h0000, 6'h3f, 8'he1);
        mem(MODE_IND, PTR_Z, 1'b0, 16'h0000, 6'h00, 8'h00);
        chk_regs();
        for (int i = 0; i < 40; i++) begin
            md = 3'($urandom % 6);
            p = (md == MODE_DISP) ? 2'(1 + $urandom % 2) : 2'($urandom % 3);
            a = 16'($urandom % 232);
            if (a >= 26 && a < 32) a = a - 16'h000a;
            mem(md, p, 1'($urandom), a, 6'($urandom), 8'($urandom));
        end
        chk_regs();
        wrp(PTR_Z, 16'h0a45);
        pcop(PC_NEXT, 12'h000);
        pcop(PC_SKIP, 12'h000);
        pcop(PC_REL, 12'h7ff);
        pcop(PC_REL, 12'h800);
        pcop(PC_PTR, 12'h000);
        pcop(PC_HOLD, 12'h000);
        cload(16'h0a45, 16'($urandom));
        cload(16'h07fe, 16'($urandom));
        conclude();
    end
endmodule
